// [logic/node_address_bitrate_config.sv]
/*
 Node address / bit rate configuration and identity register bank.
 Assumes a single-cycle word-addressed host port synchronous to clk and
 shift-register input words already assembled by the serial front end.
*/
`timescale 1ns/100ps
module node_address_bitrate_config
    import node_cfg_pkg::*;
#(
    parameter logic [31:0] PRODUCT_CODE_INIT = 32'h0000_0000 // arbitrary
)
(
    input wire logic clk,
    input wire logic rst,
    input wire node_cfg_pkg::host_req_s host_req,
    input wire logic [15:0] sync_serial_inputs,
    input wire logic sync_serial_valid,
    input wire logic [1:0] addr_source,
    input wire node_cfg_pkg::coding_e coding,
    input wire logic master_node_set,
    input wire logic [6:0] master_node,
    input wire logic master_rate_set,
    input wire logic [3:0] master_rate,
    input wire logic params_stored,
    output logic [node_cfg_pkg::WORD_W-1:0] host_rdata,
    output logic host_rvalid,
    output logic [6:0] node_addr,
    output logic [3:0] bit_rate,
    output logic config_invalid,
    output logic node_via_service,
    output logic params_temporary_flag,
    output logic address_set_by_master_flag,
    output logic rate_set_by_master_flag
);
    import node_cfg_pkg::*;

    setting_s setting;
    logic [31:0] product_code;
    logic [WORD_W-1:0] name_mem [NAME_WORDS];
    logic [WORD_W-1:0] next_rdata;
    logic [NAME_IDX_W-1:0] name_idx;
    logic in_name;
    logic serial_src;
    logic word_taken;

    node_setting_decode u_decode (
        .sync_serial_inputs(sync_serial_inputs),
        .coding(coding),
        .setting(setting)
    );

    assign serial_src = addr_source == ADDR_SRC_SERIAL;
    assign word_taken = serial_src && sync_serial_valid && !master_node_set
        && !master_rate_set;
    assign in_name = host_req.addr >= OFS_NAME_FIRST
        && host_req.addr <= OFS_NAME_LAST;
    assign name_idx = NAME_IDX_W'(host_req.addr - OFS_NAME_FIRST);

    // applied setting; master assignment overrides, invalid keeps old
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            node_addr <= NODE_VIA_SERVICE;
            bit_rate <= RATE_AUTO;
            config_invalid <= 1'b0;
            node_via_service <= 1'b1;
        end else if (master_node_set || master_rate_set) begin
            if (master_node_set) begin
                node_addr <= master_node;
                node_via_service <= 1'b0;
            end
            if (master_rate_set) begin
                bit_rate <= master_rate;
            end
        end else if (serial_src && sync_serial_valid) begin
            config_invalid <= !setting.valid;
            if (setting.valid) begin
                node_addr <= setting.node;
                bit_rate <= setting.rate;
                node_via_service <= setting.node_by_service;
            end
        end
    end

    // service status flags
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            params_temporary_flag <= SVC_STATUS_RESET[TEMP_FLAG_BIT];
            address_set_by_master_flag <= SVC_STATUS_RESET[NODE_FLAG_BIT];
            rate_set_by_master_flag <= SVC_STATUS_RESET[RATE_FLAG_BIT];
        end else begin
            params_temporary_flag <= !params_stored;
            if (master_node_set) begin
                address_set_by_master_flag <= 1'b1;
            end else if (serial_src && sync_serial_valid && setting.valid
                    && !setting.node_by_service) begin
                address_set_by_master_flag <= 1'b0;
            end
            if (master_rate_set) begin
                rate_set_by_master_flag <= 1'b1;
            end else if (serial_src && sync_serial_valid && setting.valid
                    && setting.rate != RATE_AUTO) begin
                rate_set_by_master_flag <= 1'b0;
            end
        end
    end

    // product code, two host words
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            product_code <= PRODUCT_CODE_INIT;
        end else if (host_req.wr) begin
            if (host_req.addr == OFS_PCODE_HI) begin
                product_code[31:16] <= host_req.wdata;
            end else if (host_req.addr == OFS_PCODE_LO) begin
                product_code[15:0] <= host_req.wdata;
            end
        end
    end

    // name storage; contents kept as written, trailing zeros by software
    always_ff @(posedge clk) begin
        if (host_req.wr && in_name) begin
            name_mem[name_idx] <= host_req.wdata;
        end
    end

    always_comb begin
        next_rdata = ZERO_WORD;
        if (in_name) begin
            next_rdata = name_mem[name_idx];
        end else begin
            case (host_req.addr)
                OFS_PCODE_HI: next_rdata = product_code[31:16];
                OFS_PCODE_LO: next_rdata = product_code[15:0];
                OFS_IN_IMG: next_rdata = IMAGE_SIZE_BYTES;
                OFS_OUT_IMG: next_rdata = IMAGE_SIZE_BYTES;
                OFS_SVC_STATUS: begin
                    next_rdata[TEMP_FLAG_BIT] = params_temporary_flag;
                    next_rdata[NODE_FLAG_BIT] =
                        address_set_by_master_flag;
                    next_rdata[RATE_FLAG_BIT] = rate_set_by_master_flag;
                end
                default: next_rdata = ZERO_WORD;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            host_rdata <= ZERO_WORD;
            host_rvalid <= 1'b0;
        end else begin
            host_rvalid <= host_req.rd;
            if (host_req.rd) begin
                host_rdata <= next_rdata;
            end
        end
    end

    AST_SRC_GATE: assert property (@(posedge clk) disable iff (rst)
        (!serial_src && !master_node_set && !master_rate_set)
        |=> $stable(node_addr) && $stable(bit_rate))
        else $error("setting applied with non-serial source");

    AST_SRC_FLAG: assert property (@(posedge clk) disable iff (rst)
        !serial_src && !master_node_set && !master_rate_set
        |=> $stable(config_invalid) && $stable(node_via_service))
        else $error("ignored source changed state");

    AST_INVALID_KEEPS: assert property (@(posedge clk) disable iff (rst)
        (serial_src && sync_serial_valid && coding == CODE_INVALID
         && !master_node_set && !master_rate_set)
        |=> config_invalid && $stable(node_addr))
        else $error("invalid coding applied");

    AST_REJECT_RATE: assert property (@(posedge clk) disable iff (rst)
        word_taken && coding == CODE_INVALID
        |=> $stable(bit_rate) && $stable(node_via_service))
        else $error("invalid coding changed rate");

    AST_NIBBLE: assert property (@(posedge clk) disable iff (rst)
        (serial_src && sync_serial_valid && coding == CODE_SWITCH
         && sync_serial_inputs[3:0] > DIGIT_MAX
         && !master_node_set && !master_rate_set)
        |=> config_invalid)
        else $error("bad digit accepted");

    AST_TENS: assert property (@(posedge clk) disable iff (rst)
        word_taken && coding == CODE_SWITCH
        && sync_serial_inputs[TENS_LSB +: 4] > DIGIT_MAX
        |=> config_invalid && $stable(node_addr))
        else $error("bad tens digit accepted");

    AST_SHIFT_DIGIT: assert property (@(posedge clk) disable iff (rst)
        word_taken && coding == CODE_SHIFT
        && sync_serial_inputs[UNITS_LSB +: 4] > DIGIT_MAX
        |=> config_invalid && $stable(node_addr))
        else $error("bad shift digit accepted");

    AST_SW_NODE: assert property (@(posedge clk) disable iff (rst)
        word_taken && coding == CODE_SWITCH && setting.valid
        |=> node_addr == 7'($past(sync_serial_inputs[TENS_LSB +: 4])
            * TENS_WEIGHT + $past(sync_serial_inputs[UNITS_LSB +: 4])))
        else $error("switch node wrong");

    AST_DEC_NODE: assert property (@(posedge clk) disable iff (rst)
        (serial_src && sync_serial_valid && coding == CODE_SHIFT
         && setting.valid && !master_node_set && !master_rate_set)
        |=> node_addr == 7'($past(sync_serial_inputs[7:4]) * TENS_WEIGHT
            + $past(sync_serial_inputs[3:0])) && bit_rate == RATE_AUTO)
        else $error("decimal node wrong");

    AST_SHIFT_AUTO: assert property (@(posedge clk) disable iff (rst)
        coding == CODE_SHIFT |-> setting.rate == RATE_AUTO)
        else $error("shift variant rate not automatic");

    AST_SHIFT_SVC: assert property (@(posedge clk) disable iff (rst)
        word_taken && coding == CODE_SHIFT && setting.valid
        && setting.node != NODE_VIA_SERVICE |=> !node_via_service)
        else $error("nonzero node sent to service");

    AST_BIN_NODE: assert property (@(posedge clk) disable iff (rst)
        (serial_src && sync_serial_valid && coding == CODE_BINARY
         && !master_node_set && !master_rate_set)
        |=> node_addr == 7'($past(sync_serial_inputs[5:0])) + 7'h01)
        else $error("binary node wrong");

    AST_BIN_DIRECT: assert property (@(posedge clk) disable iff (rst)
        word_taken && coding == CODE_BINARY |=> !node_via_service)
        else $error("binary node sent to service");

    AST_BIN_VALID: assert property (@(posedge clk) disable iff (rst)
        word_taken && coding == CODE_BINARY |=> !config_invalid)
        else $error("binary word rejected");

    AST_BIN_AUTO: assert property (@(posedge clk) disable iff (rst)
        word_taken && coding == CODE_BINARY
        && sync_serial_inputs[BIN_RATE_LSB +: 2] == 2'h0
        |=> bit_rate == RATE_AUTO)
        else $error("binary auto rate wrong");

    AST_BIN_250K: assert property (@(posedge clk) disable iff (rst)
        word_taken && coding == CODE_BINARY
        && sync_serial_inputs[BIN_RATE_LSB +: 2] == 2'h1
        |=> bit_rate == RATE_250K)
        else $error("binary 250k rate wrong");

    AST_BIN_500K: assert property (@(posedge clk) disable iff (rst)
        word_taken && coding == CODE_BINARY
        && sync_serial_inputs[BIN_RATE_LSB +: 2] == 2'h2
        |=> bit_rate == RATE_500K)
        else $error("binary 500k rate wrong");

    AST_BIN_RATE: assert property (@(posedge clk) disable iff (rst)
        (serial_src && sync_serial_valid && coding == CODE_BINARY
         && sync_serial_inputs[7:6] == 2'h3
         && !master_node_set && !master_rate_set)
        |=> bit_rate == RATE_1000K)
        else $error("binary rate wrong");

    AST_SW_RATE: assert property (@(posedge clk) disable iff (rst)
        (serial_src && sync_serial_valid && coding == CODE_SWITCH
         && sync_serial_inputs[11:8] > RATE_CODE_MAX
         && !master_node_set && !master_rate_set)
        |=> config_invalid)
        else $error("bad rate code accepted");

    AST_SW_RATE_SET: assert property (@(posedge clk) disable iff (rst)
        word_taken && coding == CODE_SWITCH && setting.valid
        |=> bit_rate == $past(sync_serial_inputs[RATE_LSB +: 4]))
        else $error("switch rate not applied");

    AST_ZERO_NODE: assert property (@(posedge clk) disable iff (rst)
        (serial_src && sync_serial_valid && coding == CODE_SWITCH
         && setting.valid && setting.node == NODE_VIA_SERVICE
         && !master_node_set && !master_rate_set)
        |=> node_via_service)
        else $error("zero node not routed to service");

    AST_IMG: assert property (@(posedge clk) disable iff (rst)
        host_req.rd && (host_req.addr == OFS_IN_IMG
            || host_req.addr == OFS_OUT_IMG)
        |=> host_rvalid && host_rdata == IMAGE_SIZE_BYTES)
        else $error("image size wrong");

    AST_RVALID: assert property (@(posedge clk) disable iff (rst)
        !host_req.rd |=> !host_rvalid)
        else $error("read answer without request");

    AST_TEMP_FLAG: assert property (@(posedge clk) disable iff (rst)
        ##1 params_temporary_flag == !$past(params_stored))
        else $error("temporary flag wrong");

    AST_STATUS: assert property (@(posedge clk)
        disable iff (rst) host_req.rd && host_req.addr == OFS_SVC_STATUS
        |=> host_rdata[TEMP_FLAG_BIT] == $past(params_temporary_flag)
            && host_rdata[NODE_FLAG_BIT]
                == $past(address_set_by_master_flag)
            && host_rdata[RATE_FLAG_BIT] == $past(rate_set_by_master_flag))
        else $error("status word bits misplaced");

    AST_NODE_FLAG: assert property (@(posedge clk) disable iff (rst)
        master_node_set |=> address_set_by_master_flag
            && node_addr == $past(master_node))
        else $error("master address flag wrong");

    AST_NODE_CLEAR: assert property (@(posedge clk) disable iff (rst)
        word_taken && setting.valid && !setting.node_by_service
        |=> !address_set_by_master_flag)
        else $error("serial address kept master flag");

    AST_RATE_FLAG: assert property (@(posedge clk) disable iff (rst)
        master_rate_set |=> rate_set_by_master_flag)
        else $error("master rate flag wrong");

    AST_RATE_CLEAR: assert property (@(posedge clk) disable iff (rst)
        word_taken && setting.valid && setting.rate != RATE_AUTO
        |=> !rate_set_by_master_flag)
        else $error("serial rate kept master flag");

    AST_MASTER_RATE: assert property (@(posedge clk) disable iff (rst)
        master_rate_set |=> bit_rate == $past(master_rate))
        else $error("master rate not applied");

    AST_PCODE: assert property (@(posedge clk) disable iff (rst)
        host_req.wr && host_req.addr == OFS_PCODE_LO
        ##1 host_req.rd && host_req.addr == OFS_PCODE_LO
        |=> host_rdata == $past(host_req.wdata, 2))
        else $error("product code low word lost");

    AST_PCODE_HI_WR: assert property (@(posedge clk) disable iff (rst)
        host_req.wr && host_req.addr == OFS_PCODE_HI
        |=> product_code[31:16] == $past(host_req.wdata)
            && $stable(product_code[15:0]))
        else $error("product code high word write lost");

    AST_PCODE_LO_WR: assert property (@(posedge clk) disable iff (rst)
        host_req.wr && host_req.addr == OFS_PCODE_LO
        |=> product_code[15:0] == $past(host_req.wdata)
            && $stable(product_code[31:16]))
        else $error("product code low word write lost");
endmodule // node_address_bitrate_config

// [logic/node_cfg_pkg.sv]
/*
 Shared constants and carrier types of the node address and bit rate
 configuration block. Assumes a word-addressed host register port.
*/
package node_cfg_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 16;
    localparam int NAME_WORDS = 32;
    localparam int NAME_IDX_W = 5;

    localparam logic [ADDR_W-1:0] OFS_PCODE_HI = 16'h4014;
    localparam logic [ADDR_W-1:0] OFS_PCODE_LO = 16'h4015;
    localparam logic [ADDR_W-1:0] OFS_NAME_FIRST = 16'h4016;
    localparam logic [ADDR_W-1:0] OFS_NAME_LAST = 16'h4035;
    localparam logic [ADDR_W-1:0] OFS_IN_IMG = 16'h4036;
    localparam logic [ADDR_W-1:0] OFS_OUT_IMG = 16'h4037;
    localparam logic [ADDR_W-1:0] OFS_SVC_STATUS = 16'h4101;

    localparam logic [WORD_W-1:0] IMAGE_SIZE_BYTES = 16'h0100;
    localparam logic [WORD_W-1:0] SVC_STATUS_RESET = 16'h0007;
    localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;

    localparam int TEMP_FLAG_BIT = 0;
    localparam int NODE_FLAG_BIT = 1;
    localparam int RATE_FLAG_BIT = 2;

    localparam logic [1:0] ADDR_SRC_SERIAL = 2'h1;

    localparam int UNITS_LSB = 0;
    localparam int TENS_LSB = 4;
    localparam int RATE_LSB = 8;
    localparam int BIN_RATE_LSB = 6;

    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [3:0] RATE_CODE_MAX = 4'h8;
    localparam logic [3:0] RATE_AUTO = 4'h0;
    localparam logic [3:0] RATE_250K = 4'h5;
    localparam logic [3:0] RATE_500K = 4'h6;
    localparam logic [3:0] RATE_1000K = 4'h8;
    localparam logic [6:0] NODE_VIA_SERVICE = 7'h00;
    localparam logic [6:0] TENS_WEIGHT = 7'h0A;

    typedef enum logic [1:0] {
        CODE_SWITCH = 2'b00,
        CODE_SHIFT = 2'b01,
        CODE_BINARY = 2'b10,
        CODE_INVALID = 2'b11
    } coding_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } host_req_s;

    typedef struct packed {
        logic valid;
        logic [6:0] node;
        logic [3:0] rate;
        logic node_by_service;
    } setting_s;
endpackage

// [logic/node_setting_decode.sv]
/*
 Combinational decoder from the 16 shift-register input bits to a node
 address and bit-rate code, per coding variant. Assumes stable inputs.
*/
`timescale 1ns/100ps
module node_setting_decode
    import node_cfg_pkg::*;
(
    input wire logic [15:0] sync_serial_inputs,
    input wire node_cfg_pkg::coding_e coding,
    output node_cfg_pkg::setting_s setting
);
    function automatic logic digit_ok(input logic [3:0] d);
        return d <= DIGIT_MAX;
    endfunction

    logic [3:0] units;
    logic [3:0] tens;
    logic [3:0] rate_sw;
    logic [6:0] dec_node;

    assign units = sync_serial_inputs[UNITS_LSB +: 4];
    assign tens = sync_serial_inputs[TENS_LSB +: 4];
    assign rate_sw = sync_serial_inputs[RATE_LSB +: 4];
    assign dec_node = 7'(tens * TENS_WEIGHT) + 7'(units);

    always_comb begin
        setting = '0;
        case (coding)
            CODE_SWITCH: begin
                setting.valid = digit_ok(units) && digit_ok(tens)
                    && rate_sw <= RATE_CODE_MAX;
                setting.node = dec_node;
                setting.rate = rate_sw;
                setting.node_by_service = dec_node == NODE_VIA_SERVICE;
            end
            CODE_SHIFT: begin
                setting.valid = digit_ok(units) && digit_ok(tens);
                setting.node = dec_node;
                setting.rate = RATE_AUTO;
                setting.node_by_service = dec_node == NODE_VIA_SERVICE;
            end
            CODE_BINARY: begin
                setting.valid = 1'b1;
                setting.node = 7'(sync_serial_inputs[5:0]) + 7'h01;
                case (sync_serial_inputs[BIN_RATE_LSB +: 2])
                    2'h0: setting.rate = RATE_AUTO;
                    2'h1: setting.rate = RATE_250K;
                    2'h2: setting.rate = RATE_500K;
                    default: setting.rate = RATE_1000K;
                endcase
            end
            default: setting = '0;
        endcase
    end
endmodule // node_setting_decode

// [tb/switch_shift_model.sv]
/*
 Model of the two input shift registers that carry the coding switches.
 Assumes the bench loads both bytes with a one-cycle load pulse.
*/
`timescale 1ns/100ps
module switch_shift_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [7:0] sr_hi,
    input wire logic [7:0] sr_lo,
    output logic [15:0] word,
    output logic valid
);
    logic [15:0] held;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            held <= 16'h0000;
            valid <= 1'b0;
        end else begin
            valid <= load;
            if (load) begin
                held <= {sr_hi, sr_lo};
            end
        end
    end

    // word means nothing outside valid, so show garbage there
    assign word = valid ? held : ~held;
endmodule // switch_shift_model

// [tb/tb_node_address_bitrate_config.sv]
/*
 Self-checking bench of the node address / bit rate configuration block.
 Assumes the shift register model in switch_shift_model.sv.
*/
`timescale 1ns/100ps
module tb_node_address_bitrate_config;
    import node_cfg_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    host_req_s req = '0;
    logic load = 1'b0;
    logic [7:0] sr_hi = 8'h00;
    logic [7:0] sr_lo = 8'h00;
    logic [1:0] src = 2'h1;
    coding_e coding = CODE_SWITCH;
    logic mn_set = 1'b0;
    logic mr_set = 1'b0;
    logic stored = 1'b0;
    logic [15:0] rdata, word, rv;
    logic rvalid, inval, via, f0, f1, f2, valid;
    logic [6:0] node;
    logic [3:0] rate;
    logic [3:0] bexp [4] = '{4'h0, 4'h5, 4'h6, 4'h8};
    int failures = 0;
    int cmp_count = 0;
    int cyc = 0;

    always #50 clk = ~clk;

    switch_shift_model sw (.clk(clk), .rst(rst), .load(load),
        .sr_hi(sr_hi), .sr_lo(sr_lo), .word(word), .valid(valid));

    node_address_bitrate_config dut (.clk(clk), .rst(rst),
        .host_req(req), .sync_serial_inputs(word),
        .sync_serial_valid(valid), .addr_source(src), .coding(coding),
        .master_node_set(mn_set), .master_node(7'h05),
        .master_rate_set(mr_set), .master_rate(4'h4),
        .params_stored(stored), .host_rdata(rdata), .host_rvalid(rvalid),
        .node_addr(node), .bit_rate(rate), .config_invalid(inval),
        .node_via_service(via), .params_temporary_flag(f0),
        .address_set_by_master_flag(f1), .rate_set_by_master_flag(f2));

    task end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            $display("[FAIL] run length exp under 3000 got 3000");
            end_of_test;
        end
    end

    task tick;
        @(posedge clk);
        #1;
    endtask

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("[FAIL] %s exp %h got %h", nm, e, g);
            failures++;
        end
    endtask

    task rd(input logic [15:0] a);
        req.rd = 1'b1;
        req.addr = a;
        tick;
        req.rd = 1'b0;
        chk("rvalid", 16'h0001, {15'h0000, rvalid});
        rv = rdata;
        tick;
    endtask

    task wr(input logic [15:0] a, input logic [15:0] d);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        tick;
        req.wr = 1'b0;
        tick;
    endtask

    task apply(input logic [7:0] hi, input logic [7:0] lo);
        sr_hi = hi;
        sr_lo = lo;
        load = 1'b1;
        tick;
        load = 1'b0;
        tick;
    endtask

    task chk_set(input logic [6:0] n, input logic [3:0] r, input logic i);
        chk("node", {9'h000, n}, {9'h000, node});
        chk("rate", {12'h000, r}, {12'h000, rate});
        chk("invalid", {15'h0000, i}, {15'h0000, inval});
    endtask

    task t_reset;
        chk("via", 16'h0001, {15'h0000, via});
        rd(OFS_SVC_STATUS);
        chk("status", 16'h0007, rv);
        wr(OFS_IN_IMG, 16'h1234);
        rd(OFS_IN_IMG);
        chk("in_img", 16'h0100, rv);
        rd(OFS_OUT_IMG);
        chk("out_img", 16'h0100, rv);
        rd(16'h4000);
        chk("unmapped", 16'h0000, rv);
        $display("test reset done");
    endtask

    task t_switch;
        coding = CODE_SWITCH;
        for (int r = 0; r < 9; r++) begin
            apply({4'h0, 4'(r)}, 8'h42);
            chk_set(7'd42, 4'(r), 1'b0);
        end
        apply(8'h09, 8'h17);
        chk_set(7'd42, 4'h8, 1'b1);
        apply(8'h01, 8'h1A);
        chk_set(7'd42, 4'h8, 1'b1);
        apply(8'h01, 8'hA1);
        chk_set(7'd42, 4'h8, 1'b1);
        apply(8'h02, 8'h00);
        chk_set(7'd0, 4'h2, 1'b0);
        chk("via", 16'h0001, {15'h0000, via});
        apply(8'h08, 8'h99);
        chk_set(7'd99, 4'h8, 1'b0);
        $display("test switch done");
    endtask

    task t_shift;
        coding = CODE_SHIFT;
        apply(8'h07, 8'h35);
        chk_set(7'd35, 4'h0, 1'b0);
        apply(8'h00, 8'h3B);
        chk_set(7'd35, 4'h0, 1'b1);
        $display("test shift done");
    endtask

    task t_binary;
        coding = CODE_BINARY;
        for (int i = 0; i < 4; i++) begin
            apply(8'h00, {2'(i), 6'h3D});
            chk_set(7'd62, bexp[i], 1'b0);
        end
        apply(8'h00, 8'h00);
        chk_set(7'd1, 4'h0, 1'b0);
        $display("test binary done");
    endtask

    task t_reject;
        coding = CODE_INVALID;
        apply(8'h01, 8'h05);
        chk_set(7'd1, 4'h0, 1'b1);
        coding = CODE_SWITCH;
        src = 2'h0;
        apply(8'h03, 8'h11);
        chk_set(7'd1, 4'h0, 1'b1);
        src = 2'h1;
        $display("test reject done");
    endtask

    task t_pcode;
        wr(OFS_PCODE_HI, 16'hBEEF);
        // low word written, then read back in the very next cycle
        req.wr = 1'b1;
        req.addr = OFS_PCODE_LO;
        req.wdata = 16'h1234;
        tick;
        req.wr = 1'b0;
        rd(OFS_PCODE_LO);
        chk("pcode_lo", 16'h1234, rv);
        rd(OFS_PCODE_HI);
        chk("pcode_hi", 16'hBEEF, rv);
        for (int i = 0; i < 32; i++) begin
            wr(OFS_NAME_FIRST + 16'(i), i < 2 ? 16'h4142 : 16'h0000);
        end
        rd(OFS_NAME_FIRST);
        chk("name_first", 16'h4142, rv);
        rd(OFS_NAME_LAST);
        chk("name_last", 16'h0000, rv);
        $display("test product code done");
    endtask

    task t_flags;
        stored = 1'b1;
        apply(8'h03, 8'h12);
        rd(OFS_SVC_STATUS);
        chk("status", 16'h0000, rv);
        mn_set = 1'b1;
        tick;
        mn_set = 1'b0;
        chk("node_flag", 16'h0001, {15'h0000, f1});
        chk("master_node", 16'h0005, {9'h000, node});
        chk("via", 16'h0000, {15'h0000, via});
        mr_set = 1'b1;
        tick;
        mr_set = 1'b0;
        chk("rate_flag", 16'h0001, {15'h0000, f2});
        chk("master_rate", 16'h0004, {12'h000, rate});
        rd(OFS_SVC_STATUS);
        chk("status", 16'h0006, rv);
        stored = 1'b0;
        tick;
        chk("temp_flag", 16'h0001, {15'h0000, f0});
        $display("test flags done");
    endtask

    initial begin
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset;
        t_switch;
        t_shift;
        t_binary;
        t_reject;
        t_pcode;
        t_flags;
        end_of_test;
    end
endmodule // tb_node_address_bitrate_config
